// *** rtl/acrb_pkg.sv ***
// Package with register map, field layout, reset values and timing for the gain register bank
package acrb_pkg;
    // Register offsets
    localparam logic [4:0] ADDR_POWER = 5'h00;
    localparam logic [4:0] ADDR_INSEL = 5'h01;
    localparam logic [4:0] ADDR_CLKFMT = 5'h02;
    localparam logic [4:0] ADDR_TIMER = 5'h03;
    localparam logic [4:0] ADDR_LGAIN = 5'h04;
    localparam logic [4:0] ADDR_RGAIN = 5'h05;
    localparam logic [4:0] ADDR_LCMODE = 5'h06;
    localparam logic [4:0] ADDR_LCREF = 5'h07;
    // Reset values
    localparam logic [7:0] RST_POWER = 8'h01;
    localparam logic [7:0] RST_INSEL = 8'h00;
    localparam logic [7:0] RST_CLKFMT = 8'h00;
    localparam logic [7:0] RST_TIMER = 8'h2B;
    localparam logic [7:0] RST_GAIN = 8'h7F;
    localparam logic [7:0] RST_LCMODE = 8'h28;
    localparam logic [7:0] RST_LCREF = 8'h00;
    // Writable bit masks; unused bits always read zero
    localparam logic [7:0] MASK_POWER = 8'h01;
    localparam logic [7:0] MASK_INSEL = 8'h07;
    localparam logic [7:0] MASK_CLKFMT = 8'h0F;
    localparam logic [7:0] MASK_TIMER = 8'h3F;
    localparam logic [7:0] MASK_LCMODE = 8'h3F;
    // Field positions
    localparam int POS_SOFT_POWER = 0;
    localparam int POS_SOFT_MUTE = 0;
    localparam int POS_MCLK_RATIO = 1;
    localparam int POS_FORMAT = 3;
    localparam int POS_WAIT = 0;
    localparam int POS_ZTIMEOUT = 2;
    localparam int POS_LIMPER = 4;
    localparam int POS_LC_ENABLE = 4;
    localparam int POS_IMMEDIATE = 5;
    // Gain codes
    localparam logic [7:0] GAIN_MUTE = 8'h00;
    localparam logic [7:0] GAIN_UNITY = 8'h7F;
    localparam logic [7:0] GAIN_ANALOG_MIN = 8'h80;
    localparam logic [7:0] GAIN_ANALOG_MAX = 8'h98;
    localparam logic [12:0] ATT_OFFSET = 13'h0021;
    localparam logic [12:0] ATT_FULL = 13'h1F5F;
    // Timing in sample periods
    localparam logic [12:0] TMO_0 = 13'd288;
    localparam logic [12:0] TMO_1 = 13'd1152;
    localparam logic [12:0] TMO_2 = 13'd2304;
    localparam logic [12:0] TMO_3 = 13'd4608;
    localparam logic [12:0] LIM_0 = 13'd3;
    localparam logic [12:0] LIM_1 = 13'd6;
    localparam logic [12:0] LIM_2 = 13'd12;
    localparam logic [12:0] LIM_3 = 13'd24;
    localparam logic [9:0] ZERO_FRAMES = 10'd516;
    // Decoded control for the converter
    typedef struct packed {
        logic running;
        logic soft_mute;
        logic [1:0] mclk_ratio;
        logic i2s_format;
        logic [2:0] input_source;
        logic [1:0] recovery_wait;
        logic [12:0] recovery_wait_len;
        logic level_ctrl_on;
        logic output_zero;
    } acrb_ctrl_t;
endpackage

// *** rtl/acrb_gain_channel.sv ***
// One channel of gain code handling: update timing, analog gain and soft attenuator ramp
`timescale 1ns/1ps
module acrb_gain_channel (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Sample timing
    input wire logic sample_tick,
    input wire logic zero_cross,
    // Control
    input wire logic immediate,
    input wire logic [12:0] timeout_len,
    input wire logic [12:0] limit_len,
    input wire logic force_mute,
    input wire logic [7:0] target_code,
    // Results
    output logic [7:0] applied_code,
    output logic [12:0] att_level,
    output logic [4:0] analog_step
);
    logic [7:0] applied_reg;
    logic [12:0] att_reg;
    logic [12:0] tmo_reg;
    logic [12:0] lim_reg;
    logic [4:0] step_reg;
    logic [2:0] m;
    logic [3:0] l;
    logic [12:0] att_target;
    logic pending;
    logic apply_now;
    logic [7:0] sat_code;

    // Linear level of the applied code, so the ramp waits for the update point
    assign m = applied_reg[6:4];
    assign l = applied_reg[3:0];
    assign att_target = force_mute ? 13'h0000 :
        (applied_reg >= acrb_pkg::GAIN_UNITY) ? acrb_pkg::ATT_FULL :
        13'((({8'h00, l, 1'b0} + acrb_pkg::ATT_OFFSET) << m) - acrb_pkg::ATT_OFFSET);
    assign pending = (applied_reg != target_code);
    // Zero crossing or timeout when not immediate; paced by limiter period otherwise
    assign apply_now = force_mute ||
        (immediate ? (lim_reg == 13'h0000) : (zero_cross || tmo_reg >= timeout_len));
    assign sat_code = (target_code > acrb_pkg::GAIN_ANALOG_MAX) ? acrb_pkg::GAIN_ANALOG_MAX :
        target_code;

    // Applied code and pacing counters
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            applied_reg <= acrb_pkg::GAIN_UNITY;
            tmo_reg <= 13'h0000;
            lim_reg <= 13'h0000;
        end else if (pending && sample_tick && apply_now) begin
            applied_reg <= target_code;
            tmo_reg <= 13'h0000;
            lim_reg <= limit_len - 13'h0001;
        end else if (sample_tick) begin
            tmo_reg <= pending ? tmo_reg + 13'h0001 : 13'h0000;
            lim_reg <= (lim_reg != 13'h0000) ? lim_reg - 13'h0001 : 13'h0000;
        end
    end

    // Attenuator moves one level per sample, or straight to zero on mute; a full sweep takes 8031 samples
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            att_reg <= acrb_pkg::ATT_FULL;
        end else if (sample_tick && force_mute) begin
            att_reg <= 13'h0000;
        end else if (sample_tick) begin
            if (att_reg < ((applied_reg >= acrb_pkg::GAIN_UNITY) ? acrb_pkg::ATT_FULL : att_target))
                att_reg <= att_reg + 13'h0001;
            else if (att_reg > ((applied_reg >= acrb_pkg::GAIN_UNITY) ? acrb_pkg::ATT_FULL :
                att_target))
                att_reg <= att_reg - 13'h0001;
        end
    end

    // Analog gain in half-dB steps above unity
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            step_reg <= 5'h00;
        end else if (applied_reg >= acrb_pkg::GAIN_ANALOG_MIN) begin
            step_reg <= 5'(sat_code - acrb_pkg::GAIN_ANALOG_MIN);
        end else begin
            step_reg <= 5'h00;
        end
    end

    assign applied_code = applied_reg;
    assign att_level = att_reg;
    assign analog_step = step_reg;
endmodule

// *** rtl/acrb_register_bank.sv ***
// Control register bank of the stereo converter, with gain sequencing per channel
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////////////////
module acrb_register_bank (
    // Clock and reset
    mclk,
    reset_n,
    // Device pins
    power_down_pin_n,
    ctrl_mode_pin,
    input_source_pins,
    soft_mute_pin,
    level_ctrl_pin,
    // Sample timing from the audio interface
    frame_tick,
    zero_cross_left,
    zero_cross_right,
    // Register write and read port from the serial control decoder
    wr_strobe,
    rd_addr,
    wr_addr,
    wr_data,
    rd_data,
    // Converter control
    ctrl,
    left_att,
    right_att,
    left_analog,
    right_analog
);
    input wire logic mclk;
    input wire logic reset_n;
    input wire logic power_down_pin_n;
    input wire logic ctrl_mode_pin;
    input wire logic [2:0] input_source_pins;
    input wire logic soft_mute_pin;
    input wire logic level_ctrl_pin;
    input wire logic frame_tick;
    input wire logic zero_cross_left;
    input wire logic zero_cross_right;
    input wire logic wr_strobe;
    input wire logic [4:0] rd_addr;
    input wire logic [4:0] wr_addr;
    input wire logic [7:0] wr_data;
    output logic [7:0] rd_data;
    output acrb_pkg::acrb_ctrl_t ctrl;
    output logic [12:0] left_att;
    output logic [12:0] right_att;
    output logic [4:0] left_analog;
    output logic [4:0] right_analog;

    //////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;
    logic pd_n;
    logic ctrl_mode;
    logic [2:0] sel_pins;
    logic mute_pin;
    logic lc_pin;

    // Two flops on every asynchronous pin before use
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= {power_down_pin_n, ctrl_mode_pin, input_source_pins,
                soft_mute_pin, level_ctrl_pin, 1'b0};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign pd_n = pin_sync_reg[7];
    assign ctrl_mode = pin_sync_reg[6];
    assign sel_pins = pin_sync_reg[5:3];
    assign mute_pin = pin_sync_reg[2];
    assign lc_pin = pin_sync_reg[1];

    //////////////////////////////////////////////////////////////////////////////////////
    // Register file
    logic [7:0] power_control_reg;
    logic [7:0] input_source_select_reg;
    logic [7:0] clock_format_mute_reg;
    logic [7:0] level_timer_select_reg;
    logic [7:0] left_gain_code_reg;
    logic [7:0] right_gain_code_reg;
    logic [7:0] level_control_mode_one_reg;
    logic [7:0] level_control_reference_reg;
    logic lc_active;
    logic analog_write;
    logic gain_write_ok;
    logic [7:0] rd_next;

    // Level control is the OR of pin and bit
    assign lc_active = lc_pin | level_control_mode_one_reg[acrb_pkg::POS_LC_ENABLE];
    assign analog_write = (wr_data >= acrb_pkg::GAIN_ANALOG_MIN);
    assign gain_write_ok = !(lc_active && analog_write);

    // Writes decode by address; pin low holds defaults, beyond 07H nothing is touched
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            power_control_reg <= acrb_pkg::RST_POWER;
            input_source_select_reg <= acrb_pkg::RST_INSEL;
            clock_format_mute_reg <= acrb_pkg::RST_CLKFMT;
            level_timer_select_reg <= acrb_pkg::RST_TIMER;
            left_gain_code_reg <= acrb_pkg::RST_GAIN;
            right_gain_code_reg <= acrb_pkg::RST_GAIN;
            level_control_mode_one_reg <= acrb_pkg::RST_LCMODE;
            level_control_reference_reg <= acrb_pkg::RST_LCREF;
        end else if (!pd_n) begin
            power_control_reg <= acrb_pkg::RST_POWER;
            input_source_select_reg <= acrb_pkg::RST_INSEL;
            clock_format_mute_reg <= acrb_pkg::RST_CLKFMT;
            level_timer_select_reg <= acrb_pkg::RST_TIMER;
            left_gain_code_reg <= acrb_pkg::RST_GAIN;
            right_gain_code_reg <= acrb_pkg::RST_GAIN;
            level_control_mode_one_reg <= acrb_pkg::RST_LCMODE;
            level_control_reference_reg <= acrb_pkg::RST_LCREF;
        end else if (wr_strobe) begin
            // Writes are accepted while soft powered down
            case (wr_addr)
                acrb_pkg::ADDR_POWER: power_control_reg <= wr_data & acrb_pkg::MASK_POWER;
                acrb_pkg::ADDR_INSEL: input_source_select_reg <= wr_data & acrb_pkg::MASK_INSEL;
                acrb_pkg::ADDR_CLKFMT: clock_format_mute_reg <= wr_data & acrb_pkg::MASK_CLKFMT;
                acrb_pkg::ADDR_TIMER: level_timer_select_reg <= wr_data & acrb_pkg::MASK_TIMER;
                acrb_pkg::ADDR_LGAIN: if (gain_write_ok) left_gain_code_reg <= wr_data;
                acrb_pkg::ADDR_RGAIN: if (gain_write_ok) right_gain_code_reg <= wr_data;
                acrb_pkg::ADDR_LCMODE: level_control_mode_one_reg <= wr_data & acrb_pkg::MASK_LCMODE;
                acrb_pkg::ADDR_LCREF: level_control_reference_reg <= wr_data;
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero
    assign rd_next = (rd_addr == acrb_pkg::ADDR_POWER) ? power_control_reg :
        (rd_addr == acrb_pkg::ADDR_INSEL) ? input_source_select_reg :
        (rd_addr == acrb_pkg::ADDR_CLKFMT) ? clock_format_mute_reg :
        (rd_addr == acrb_pkg::ADDR_TIMER) ? level_timer_select_reg :
        (rd_addr == acrb_pkg::ADDR_LGAIN) ? left_gain_code_reg :
        (rd_addr == acrb_pkg::ADDR_RGAIN) ? right_gain_code_reg :
        (rd_addr == acrb_pkg::ADDR_LCMODE) ? level_control_mode_one_reg :
        (rd_addr == acrb_pkg::ADDR_LCREF) ? level_control_reference_reg : 8'h00;

    //////////////////////////////////////////////////////////////////////////////////////
    // Power sequencing
    typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_WAKE} acrb_pwr_t;
    acrb_pwr_t pwr_reg;
    acrb_pwr_t pwr_next;
    logic [9:0] frame_cnt_reg;
    logic soft_power;
    logic mute_gains;

    assign soft_power = power_control_reg[acrb_pkg::POS_SOFT_POWER];
    // Pin low or power bit low both send the gains to mute
    assign mute_gains = !pd_n || !soft_power;

    // Next power state
    always_comb begin
        pwr_next = pwr_reg;
        case (pwr_reg)
            PWR_RUN: if (mute_gains) pwr_next = PWR_DOWN;
            PWR_DOWN: if (!mute_gains) pwr_next = PWR_WAKE;
            PWR_WAKE: begin
                if (mute_gains)
                    pwr_next = PWR_DOWN;
                else if (frame_tick && frame_cnt_reg == acrb_pkg::ZERO_FRAMES - 10'd1)
                    pwr_next = PWR_RUN;
            end
            default: pwr_next = PWR_DOWN;
        endcase
    end

    // Count frames of zero output after wake
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_reg <= PWR_RUN;
            frame_cnt_reg <= 10'h000;
        end else begin
            pwr_reg <= pwr_next;
            if (pwr_reg != PWR_WAKE)
                frame_cnt_reg <= 10'h000;
            else if (frame_tick)
                frame_cnt_reg <= frame_cnt_reg + 10'd1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Timer decode and gain channels
    logic [12:0] timeout_len;
    logic [12:0] limit_len;
    logic [12:0] wait_len;
    logic [1:0] ztm;
    logic [1:0] ltm;
    logic [1:0] wtm;
    logic immediate;
    logic [12:0] latt;
    logic [12:0] recovery_step_bit;
    logic [4:0] lana;
    logic [4:0] rana;

    assign wtm = level_timer_select_reg[acrb_pkg::POS_WAIT +: 2];
    assign ztm = level_timer_select_reg[acrb_pkg::POS_ZTIMEOUT +: 2];
    assign ltm = level_timer_select_reg[acrb_pkg::POS_LIMPER +: 2];
    assign immediate = level_control_mode_one_reg[acrb_pkg::POS_IMMEDIATE];
    assign wait_len = (wtm == 2'b00) ? acrb_pkg::TMO_0 : (wtm == 2'b01) ? acrb_pkg::TMO_1 :
        (wtm == 2'b10) ? acrb_pkg::TMO_2 : acrb_pkg::TMO_3;
    assign timeout_len = (ztm == 2'b00) ? acrb_pkg::TMO_0 : (ztm == 2'b01) ? acrb_pkg::TMO_1 :
        (ztm == 2'b10) ? acrb_pkg::TMO_2 : acrb_pkg::TMO_3;
    assign limit_len = (ltm == 2'b00) ? acrb_pkg::LIM_0 : (ltm == 2'b01) ? acrb_pkg::LIM_1 :
        (ltm == 2'b10) ? acrb_pkg::LIM_2 : acrb_pkg::LIM_3;

    // Channels follow the last accepted host code even after level control drops
    acrb_gain_channel u_left (
        .mclk(mclk),
        .reset_n(reset_n),
        .sample_tick(frame_tick),
        .zero_cross(zero_cross_left),
        .immediate(immediate),
        .timeout_len(timeout_len),
        .limit_len(limit_len),
        .force_mute(mute_gains),
        .target_code(left_gain_code_reg),
        .applied_code(),
        .att_level(latt),
        .analog_step(lana)
    );
    acrb_gain_channel u_right (
        .mclk(mclk),
        .reset_n(reset_n),
        .sample_tick(frame_tick),
        .zero_cross(zero_cross_right),
        .immediate(immediate),
        .timeout_len(timeout_len),
        .limit_len(limit_len),
        .force_mute(mute_gains),
        .target_code(right_gain_code_reg),
        .applied_code(),
        .att_level(recovery_step_bit),
        .analog_step(rana)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    acrb_pkg::acrb_ctrl_t ctrl_next;

    // Nonzero selector pins win over bits; mute and format pins OR with their bits
    always_comb begin
        ctrl_next.running = (pwr_reg != PWR_DOWN) && !mute_gains;
        ctrl_next.soft_mute = clock_format_mute_reg[acrb_pkg::POS_SOFT_MUTE] | mute_pin;
        ctrl_next.mclk_ratio = clock_format_mute_reg[acrb_pkg::POS_MCLK_RATIO +: 2];
        ctrl_next.i2s_format = clock_format_mute_reg[acrb_pkg::POS_FORMAT] | ctrl_mode;
        ctrl_next.input_source = (sel_pins != 3'b000) ? sel_pins :
            input_source_select_reg[2:0];
        ctrl_next.recovery_wait = wtm;
        ctrl_next.recovery_wait_len = wait_len;
        ctrl_next.level_ctrl_on = lc_active;
        ctrl_next.output_zero = (pwr_reg != PWR_RUN);
    end

    // Clock changes need no handling here; the outputs simply follow the registers
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data <= 8'h00;
            ctrl <= '0;
            left_att <= 13'h0000;
            right_att <= 13'h0000;
            left_analog <= 5'h00;
            right_analog <= 5'h00;
        end else begin
            rd_data <= rd_next;
            ctrl <= ctrl_next;
            left_att <= latt;
            right_att <= recovery_step_bit;
            left_analog <= lana;
            right_analog <= rana;
        end
    end
endmodule

// *** verif/acrb_monitor.sv ***
// Port checker for the gain register bank
`timescale 1ns/1ps
module acrb_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Pins and host read address
    input wire logic power_down_pin_n,
    input wire logic ctrl_mode_pin,
    input wire logic [2:0] input_source_pins,
    input wire logic soft_mute_pin,
    input wire logic frame_tick,
    input wire logic [4:0] rd_addr,
    // Results
    input wire logic [7:0] rd_data,
    input wire acrb_pkg::acrb_ctrl_t ctrl,
    input wire logic [12:0] left_att,
    input wire logic [4:0] left_analog
);
    logic [3:0] warm_reg;
    logic [3:0] warm_next;
    wire warm = (warm_reg == 4'hF);
    // Settle count hides the pin synchroniser start-up after every reset
    assign warm_next = warm ? warm_reg : warm_reg + 4'h1;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) warm_reg <= 4'h0;
        else warm_reg <= warm_next;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////////
    a_att_in_range: assert property (left_att <= acrb_pkg::ATT_FULL)
        else $error("left attenuation above full scale");
    a_analog_in_range: assert property (left_analog <= 5'h18)
        else $error("left analog step above twelve decibels");
    a_att_paced: assert property (warm && $changed(left_att) |->
        $past(frame_tick) || $past(frame_tick, 2) || $past(frame_tick, 3))
        else $error("attenuation moved without a sample tick");
    a_i2s_pin_forced: assert property ((warm && ctrl_mode_pin)[*4] |-> ctrl.i2s_format)
        else $error("mode pin high but format not forced");
    a_mute_pin_ored: assert property ((warm && soft_mute_pin)[*4] |-> ctrl.soft_mute)
        else $error("mute pin high but output not muted");
    a_source_pins_win: assert property ((warm && input_source_pins != 3'h0 &&
        $stable(input_source_pins))[*4] |-> ctrl.input_source == input_source_pins)
        else $error("selector pins did not override register");
    a_pin_reset_regs: assert property ((!power_down_pin_n)[*5] ##1
        (!power_down_pin_n && rd_addr == acrb_pkg::ADDR_TIMER)[*2] |->
        rd_data == acrb_pkg::RST_TIMER)
        else $error("timer register not at default while pin low");
    a_unused_bits_zero: assert property ((rd_addr == acrb_pkg::ADDR_POWER)[*2] |->
        rd_data[7:1] == 7'h00)
        else $error("unused power register bits read nonzero");
    a_power_off_zero: assert property (warm && power_down_pin_n && $fell(ctrl.running) |->
        ##[0:2] ctrl.output_zero)
        else $error("power bit cleared but output not zeroed");
    // Main scenarios reached
    c_power_off: cover property ($fell(ctrl.running));
    c_analog_gain: cover property (left_analog == 5'h10);
    c_att_ramp: cover property (warm && $changed(left_att));
endmodule
bind acrb_register_bank acrb_monitor i_acrb_monitor (.mclk(mclk), .reset_n(reset_n),
    .power_down_pin_n(power_down_pin_n), .ctrl_mode_pin(ctrl_mode_pin),
    .input_source_pins(input_source_pins), .soft_mute_pin(soft_mute_pin),
    .frame_tick(frame_tick), .rd_addr(rd_addr), .rd_data(rd_data), .ctrl(ctrl),
    .left_att(left_att), .left_analog(left_analog));

// *** verif/acrb_host_model.sv ***
// Host controller model driving the register write and read port
`timescale 1ns/1ps
module acrb_host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output logic wr_strobe,
    output logic [4:0] wr_addr,
    output logic [7:0] wr_data,
    output logic [4:0] rd_addr,
    input wire logic [7:0] rd_data
);
    initial begin
        wr_strobe = 1'b0;
        wr_addr = 5'h1F;
        wr_data = 8'h00;
        rd_addr = 5'h00;
    end
    // One write; address and data are only meaningful with the strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        wr_strobe <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge mclk);
        wr_strobe <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d; // Released bus never shows the old byte
    endtask
    // Read; data is registered one cycle after the address
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd_addr <= a;
        repeat (2) @(posedge mclk);
        #1 d = rd_data;
    endtask
endmodule

// *** verif/testbench.sv ***
// Self-checking bench of the gain register bank
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic power_down_pin_n = 1'b1;
    logic ctrl_mode_pin = 1'b0;
    logic [2:0] input_source_pins = 3'h0;
    logic soft_mute_pin = 1'b0;
    logic level_ctrl_pin = 1'b0;
    logic frame_tick = 1'b0;
    logic zero_cross_left = 1'b0;
    logic zero_cross_right = 1'b0;
    logic [1:0] tick_cnt = 2'h0;
    logic wr_strobe;
    logic [4:0] rd_addr, wr_addr, a;
    logic [7:0] wr_data, rd_data, got, code;
    acrb_pkg::acrb_ctrl_t ctrl;
    logic [12:0] left_att, right_att, tmo [4];
    logic [4:0] left_analog, right_analog;
    logic [7:0] sh [8], msk [8], rst [8];
    int errors = 0;
    int tests_run = 0;
    acrb_register_bank i_acrb_register_bank (.mclk(mclk), .reset_n(reset_n),
        .power_down_pin_n(power_down_pin_n), .ctrl_mode_pin(ctrl_mode_pin),
        .input_source_pins(input_source_pins), .soft_mute_pin(soft_mute_pin),
        .level_ctrl_pin(level_ctrl_pin), .frame_tick(frame_tick),
        .zero_cross_left(zero_cross_left), .zero_cross_right(zero_cross_right),
        .wr_strobe(wr_strobe), .rd_addr(rd_addr), .wr_addr(wr_addr), .wr_data(wr_data),
        .rd_data(rd_data), .ctrl(ctrl), .left_att(left_att), .right_att(right_att),
        .left_analog(left_analog), .right_analog(right_analog));
    acrb_host_model i_acrb_host_model (.mclk(mclk), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data));
    always #10 mclk = ~mclk;
    // Sample tick every fourth cycle, zero crossings at random
    always @(posedge mclk) begin
        tick_cnt <= tick_cnt + 2'h1;
        frame_tick <= (tick_cnt == 2'h3);
        zero_cross_left <= 1'($urandom_range(1));
        zero_cross_right <= 1'($urandom_range(1));
    end
    // Attenuation level of a code; unity and analog codes sit at full scale
    function automatic logic [12:0] att_of(input logic [7:0] c);
        if (c >= acrb_pkg::GAIN_UNITY) return acrb_pkg::ATT_FULL;
        return 13'((14'h1 << c[6:4]) * (14'h2 * c[3:0] + 14'h21) - 14'h21);
    endfunction
    task automatic chk(input logic [12:0] g, input logic [12:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t value %0h expected %0h", $time, g, e);
        end
    endtask
    task automatic rchk(input logic [4:0] ad, input logic [7:0] e);
        i_acrb_host_model.rd(ad, got);
        tests_run++;
        if (got !== e) begin
            errors++;
            $display("[FAIL] %0t register %0h read %0h expected %0h", $time, ad, got, e);
        end
    endtask
    task automatic wsh(input logic [4:0] ad, input logic [7:0] d);
        i_acrb_host_model.wr(ad, d);
        sh[ad[2:0]] = d & msk[ad[2:0]];
    endtask
    task automatic ticks(input int n);
        repeat (n * 4) @(posedge mclk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (99000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
    initial begin
        rst = '{acrb_pkg::RST_POWER, acrb_pkg::RST_INSEL, acrb_pkg::RST_CLKFMT,
            acrb_pkg::RST_TIMER, acrb_pkg::RST_GAIN, acrb_pkg::RST_GAIN,
            acrb_pkg::RST_LCMODE, acrb_pkg::RST_LCREF};
        sh = rst;
        msk = '{acrb_pkg::MASK_POWER, acrb_pkg::MASK_INSEL, acrb_pkg::MASK_CLKFMT,
            acrb_pkg::MASK_TIMER, 8'hFF, 8'hFF, acrb_pkg::MASK_LCMODE, 8'hFF};
        tmo = '{acrb_pkg::TMO_0, acrb_pkg::TMO_1, acrb_pkg::TMO_2, acrb_pkg::TMO_3};
        void'($urandom(69));
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (6) @(posedge mclk);
        for (int i = 0; i < 8; i++) rchk(5'(i), sh[i]);
        ticks(7990);
        chk(13'(left_att < acrb_pkg::ATT_FULL), 13'h1);
        ticks(60);
        chk(left_att, acrb_pkg::ATT_FULL);
        $display("test defaults and start-up ramp done");
        for (int i = 0; i < 16; i++) begin
            a = 5'(i % 4 == 3 ? 7 : i % 4 + 1);
            wsh(a, 8'($urandom) & msk[a[2:0]]);
            rchk(a, sh[a[2:0]]);
        end
        i_acrb_host_model.wr(5'(8 + $urandom_range(23)), 8'hFF);
        for (int i = 0; i < 8; i++) rchk(5'(i), sh[i]);
        chk(13'(ctrl.mclk_ratio), 13'(sh[2][2:1]));
        chk(ctrl.recovery_wait_len, tmo[sh[3][1:0]]);
        $display("test register access done");
        @(posedge mclk);
        ctrl_mode_pin <= 1'b1;
        soft_mute_pin <= 1'b1;
        input_source_pins <= 3'($urandom_range(4, 1));
        repeat (6) @(posedge mclk);
        chk(13'(ctrl.i2s_format), 13'h1);
        chk(13'(ctrl.soft_mute), 13'h1);
        chk(13'(ctrl.input_source), 13'(input_source_pins));
        ctrl_mode_pin <= 1'b0;
        soft_mute_pin <= 1'b0;
        input_source_pins <= 3'h0;
        repeat (6) @(posedge mclk);
        chk(13'({ctrl.soft_mute, ctrl.i2s_format}), 13'({sh[2][0], sh[2][3]}));
        chk(13'(ctrl.input_source), 13'(sh[1][2:0]));
        $display("test pins done");
        wsh(acrb_pkg::ADDR_LCMODE, 8'h08);
        code = 8'h70 | 8'($urandom_range(15));
        wsh(acrb_pkg::ADDR_LGAIN, 8'h7E);
        wsh(acrb_pkg::ADDR_RGAIN, code);
        ticks(250);
        chk(13'(left_att > att_of(8'h7E)), 13'h1);
        ticks(40);
        chk(left_att, att_of(8'h7E));
        ticks(8031 - int'(att_of(code)) - 250);
        chk(right_att, att_of(code));
        chk(13'(right_analog), 13'h0);
        wsh(acrb_pkg::ADDR_LGAIN, 8'h90);
        ticks(300);
        chk(13'(left_analog), 13'h10);
        i_acrb_host_model.wr(acrb_pkg::ADDR_LCMODE, 8'h38);
        i_acrb_host_model.wr(acrb_pkg::ADDR_LGAIN, 8'h98);
        rchk(acrb_pkg::ADDR_LGAIN, 8'h90);
        chk(13'(ctrl.level_ctrl_on), 13'h1);
        wsh(acrb_pkg::ADDR_LGAIN, 8'h40);
        rchk(acrb_pkg::ADDR_LGAIN, 8'h40);
        wsh(acrb_pkg::ADDR_LCMODE, acrb_pkg::RST_LCMODE);
        $display("test gain codes done");
        wsh(acrb_pkg::ADDR_POWER, 8'h00);
        ticks(3);
        chk(13'({ctrl.running, ctrl.output_zero}), 13'h1);
        chk(left_att, 13'h0000);
        wsh(acrb_pkg::ADDR_INSEL, 8'h03);
        rchk(acrb_pkg::ADDR_INSEL, 8'h03);
        wsh(acrb_pkg::ADDR_POWER, 8'h01);
        ticks(510);
        chk(13'({ctrl.running, ctrl.output_zero}), 13'h3);
        ticks(12);
        chk(13'(ctrl.output_zero), 13'h0);
        $display("test power bit done");
        power_down_pin_n <= 1'b0;
        ticks(3);
        chk(left_att, 13'h0000);
        for (int i = 0; i < 8; i++) rchk(5'(i), rst[i]);
        power_down_pin_n <= 1'b1;
        $display("test power pin done");
        tally_and_finish();
    end
endmodule
